//--- smrc_pkg.sv
// Shared constants for the supply monitor reset control block
package smrc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_HZ        = 20_000_000;   // System clock rate
  localparam int unsigned TIMEOUT_MS    = 100;          // Monitor timeout
  localparam int unsigned TIMEOUT_CYC   = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int unsigned CNT_W         = 21;           // Holds TIMEOUT_CYC
  localparam logic [20:0] SHORT_CYC     = 21'h000010;   // Non-power resets
  localparam logic [3:0]  PIN_SETTLE    = 4'h8;         // Pin echo blanking

  ////////////////////////////////////////////////////////////////////////////
  // Reset source register layout
  localparam int unsigned SRC_W         = 8;
  localparam int unsigned POR_FLAG_BIT  = 1;
  localparam logic [7:0]  SRC_RESET     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Start address after any reset
  localparam logic [15:0] BOOT_VECTOR   = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised input lanes
  localparam int unsigned NUM_SYNC      = 3;
  localparam int unsigned LANE_SUPPLY   = 0;
  localparam int unsigned LANE_MON_EN   = 1;
  localparam int unsigned LANE_PIN      = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [2:0] {
    ST_HOLD    = 3'b000,   // Waiting for supply above threshold
    ST_TIMEOUT = 3'b001,   // Long monitor timeout running
    ST_SHORT   = 3'b010,   // Brief reset for other causes
    ST_RUN     = 3'b011    // Reset released
  } smrc_state_t;

  // Cause of the most recent reset
  typedef enum logic [1:0] {
    CAUSE_POWER_ON = 2'b00,
    CAUSE_FAIL     = 2'b01,
    CAUSE_SOFT     = 2'b10,
    CAUSE_OTHER    = 2'b11
  } smrc_cause_t;

endpackage : smrc_pkg

//--- smrc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module smrc_sync #(
  parameter logic RESET_VAL = 1'b0          // Value held under reset
) (
  input  wire logic sys_clk_in,             // System clock
  input  wire logic rst_b_in,               // Async reset, active low
  input  wire logic async_in,               // Raw outside level
  output logic      level_out               // Filtered level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      level_out <= RESET_VAL;
    end else if (s2_r == s3_r) begin
      level_out <= s3_r;
    end
  end

endmodule : smrc_sync

//--- smrc_timer.sv
// Reset timeout counter with restart and terminal compare
`timescale 1ns/1ps
module smrc_timer (
  input  wire logic                      sys_clk_in,  // System clock
  input  wire logic                      rst_b_in,    // Async reset
  input  wire logic                      clear_in,    // Restart count
  input  wire logic [smrc_pkg::CNT_W-1:0] term_in,    // Cycles to count
  output logic                           done_out     // Count reached
);

  logic [smrc_pkg::CNT_W-1:0] count_r;

  // Count up until the terminal value, then hold done
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_r  <= '0;
      done_out <= 1'b0;
    end else if (clear_in) begin
      count_r  <= '0;
      done_out <= 1'b0;
    end else if (!done_out) begin
      if (count_r == term_in - 1'b1) begin
        done_out <= 1'b1;
      end else begin
        count_r <= count_r + 1'b1;
      end
    end
  end

endmodule : smrc_timer

//--- smrc_top.sv
// Supply monitor reset sequencer and power-on flag
`timescale 1ns/1ps
module smrc_top #(
  parameter int unsigned TIMEOUT_CYC = smrc_pkg::TIMEOUT_CYC, // Long hold
  parameter bit          HAS_MON_EN  = 1'b1   // Variant with enable pin
) (
  input  wire logic        sys_clk_in,         // System clock, 20 MHz
  input  wire logic        rst_b_in,           // Power-on reset, low
  input  wire logic        supply_good_in,     // Comparator, above thresh
  input  wire logic        monitor_enable_input_in, // Monitor enable pin
  input  wire logic        rst_pin_in,         // Reset pin level
  input  wire logic        other_reset_in,     // Internal reset request
  input  wire logic        src_wr_in,          // Source register write
  input  wire logic [7:0]  src_wdata_in,       // Source write data
  output logic             rst_pin_out,        // Reset pin drive value
  output logic             rst_pin_oe_out,     // Reset pin drive enable
  output logic             sys_rst_b_out,      // Core reset, active low
  output logic [7:0]       reset_source_register_out, // Source flags
  output logic [15:0]      boot_vector_out,    // Start address
  output logic [1:0]       reset_cause_out,    // Last reset cause
  output logic             monitor_active_out  // Monitoring in force
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam logic [smrc_pkg::CNT_W-1:0] LONG_TERM =
    smrc_pkg::CNT_W'(TIMEOUT_CYC);

  logic [smrc_pkg::NUM_SYNC-1:0] raw_lanes;
  logic [smrc_pkg::NUM_SYNC-1:0] sync_lanes;

  logic                          supply_ok;
  logic                          mon_en_sync;
  logic                          pin_low;
  logic                          mon_active;
  logic                          supply_fail;
  logic                          soft_force;
  logic                          pin_reset;
  logic                          timer_clear;
  logic                          timer_done;
  logic [smrc_pkg::CNT_W-1:0]    timer_term;
  logic                          exit_strobe;

  // Sequencer state and the cause it serves
  smrc_pkg::smrc_state_t         state_r;
  smrc_pkg::smrc_state_t         state_nxt;
  smrc_pkg::smrc_cause_t         cause_r;
  smrc_pkg::smrc_cause_t         cause_nxt;
  logic                          por_kind_r;
  logic                          por_kind_nxt;
  logic                          por_flag_r;
  logic [3:0]                    settle_r;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for pins from outside the clock domain

  assign raw_lanes[smrc_pkg::LANE_SUPPLY] = supply_good_in;
  assign raw_lanes[smrc_pkg::LANE_MON_EN] = monitor_enable_input_in;
  assign raw_lanes[smrc_pkg::LANE_PIN]    = rst_pin_in;

  // One filtered synchroniser per lane
  generate
    for (genvar i = 0; i < smrc_pkg::NUM_SYNC; i++) begin : g_sync
      smrc_sync #(
        .RESET_VAL (i != smrc_pkg::LANE_SUPPLY)
      ) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .async_in   (raw_lanes[i]),
        .level_out  (sync_lanes[i])
      );
    end
  endgenerate

  assign supply_ok   = sync_lanes[smrc_pkg::LANE_SUPPLY];
  assign mon_en_sync = sync_lanes[smrc_pkg::LANE_MON_EN];
  assign pin_low     = ~sync_lanes[smrc_pkg::LANE_PIN];

  ////////////////////////////////////////////////////////////////////////////
  // Monitor enable and failure detection

  // Variant without the pin ignores it and keeps monitoring on
  assign mon_active  = HAS_MON_EN ? mon_en_sync : 1'b1;

  // Supply below threshold while monitoring
  assign supply_fail = mon_active & ~supply_ok;

  // Software writes one to the power-on flag bit
  assign soft_force  = src_wr_in &
                       src_wdata_in[smrc_pkg::POR_FLAG_BIT];

  // Outside party pulls the reset pin, once our own echo has settled
  assign pin_reset   = pin_low & (settle_r == 4'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Timeout counter

  // Restart whenever not counting or the supply drops away
  assign timer_clear = ((state_r != smrc_pkg::ST_TIMEOUT) &&
                        (state_r != smrc_pkg::ST_SHORT)) ||
                       !supply_ok;

  // Long timeout for power resets, short hold for the rest
  assign timer_term  = (state_r == smrc_pkg::ST_SHORT) ?
                       smrc_pkg::SHORT_CYC : LONG_TERM;

  smrc_timer u_timer (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .clear_in   (timer_clear),
    .term_in    (timer_term),
    .done_out   (timer_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state

  always_comb begin
    state_nxt    = state_r;
    cause_nxt    = cause_r;
    por_kind_nxt = por_kind_r;
    unique case (state_r)
      // Wait for the supply regardless of monitor enable
      smrc_pkg::ST_HOLD: begin
        if (supply_ok) begin
          state_nxt = smrc_pkg::ST_TIMEOUT;
        end
      end
      // Long timeout, restarted if the supply drops
      smrc_pkg::ST_TIMEOUT: begin
        if (!supply_ok) begin
          state_nxt = smrc_pkg::ST_HOLD;
        end else if (timer_done) begin
          state_nxt = smrc_pkg::ST_RUN;
        end
      end
      // Brief hold for internal or pin resets
      smrc_pkg::ST_SHORT: begin
        if (supply_fail) begin
          state_nxt    = smrc_pkg::ST_HOLD;
          cause_nxt    = smrc_pkg::CAUSE_FAIL;
          por_kind_nxt = 1'b1;
        end else if (timer_done) begin
          state_nxt = smrc_pkg::ST_RUN;
        end
      end
      // Running; supply loss outranks software and other resets
      smrc_pkg::ST_RUN: begin
        if (supply_fail) begin
          // Supply failure: the flag and the reset cause both report it
          state_nxt    = smrc_pkg::ST_HOLD;
          cause_nxt    = smrc_pkg::CAUSE_FAIL;
          por_kind_nxt = 1'b1;
        end else if (soft_force) begin
          state_nxt    = smrc_pkg::ST_HOLD;
          cause_nxt    = smrc_pkg::CAUSE_SOFT;
          por_kind_nxt = 1'b1;
        end else if (other_reset_in || pin_reset) begin
          state_nxt    = smrc_pkg::ST_SHORT;
          cause_nxt    = smrc_pkg::CAUSE_OTHER;
          por_kind_nxt = 1'b0;
        end
      end
      default: begin
        // Illegal codes fall back to a cold hold
        state_nxt    = smrc_pkg::ST_HOLD;
        por_kind_nxt = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state registers

  // Current sequencer state
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= smrc_pkg::ST_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Cause being served; power-on after a cold start
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cause_r <= smrc_pkg::CAUSE_POWER_ON;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // Whether the pending exit counts as a power kind
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      por_kind_r <= 1'b1;
    end else begin
      por_kind_r <= por_kind_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-on flag

  // Edge on which reset is left for the running state
  assign exit_strobe = (state_r != smrc_pkg::ST_RUN) &&
                       (state_nxt == smrc_pkg::ST_RUN);

  // Updated only as reset is left: set for power kinds, else cleared
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      por_flag_r <= 1'b0;
    end else if (exit_strobe) begin
      por_flag_r <= por_kind_r;
    end
  end

  // Register view: flag at its bit, other cause bits read zero
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reset_source_register_out <= smrc_pkg::SRC_RESET;
    end else begin
      reset_source_register_out <= smrc_pkg::SRC_RESET;
      reset_source_register_out[smrc_pkg::POR_FLAG_BIT] <=
        exit_strobe ? por_kind_r : por_flag_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset outputs

  // Core reset follows the next state
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sys_rst_b_out <= 1'b0;
    end else begin
      sys_rst_b_out <= (state_nxt == smrc_pkg::ST_RUN);
    end
  end

  // Open-drain pin: value fixed low, enable carries the reset
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_pin_out    <= 1'b0;
      rst_pin_oe_out <= 1'b1;
    end else begin
      rst_pin_out    <= 1'b0;
      rst_pin_oe_out <= (state_nxt != smrc_pkg::ST_RUN);
    end
  end

  // Blank the pin input while our own drive fades after release
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      settle_r <= smrc_pkg::PIN_SETTLE;
    end else if (state_r != smrc_pkg::ST_RUN) begin
      settle_r <= smrc_pkg::PIN_SETTLE;
    end else if (settle_r != 4'h0) begin
      settle_r <= settle_r - 4'h1;
    end
  end

  // Start address is the same for every cause
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      boot_vector_out <= smrc_pkg::BOOT_VECTOR;
    end else begin
      boot_vector_out <= smrc_pkg::BOOT_VECTOR;
    end
  end

  // Status: cause of the most recent reset
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reset_cause_out <= 2'h0;
    end else begin
      reset_cause_out <= cause_nxt;
    end
  end

  // Status: monitoring in force
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      monitor_active_out <= 1'b0;
    end else begin
      monitor_active_out <= mon_active;
    end
  end

endmodule : smrc_top

//--- smrc_top_chk.sv
// Assertion checker for the supply monitor reset top
`timescale 1ns/1ps
module smrc_top_chk #(
  parameter int unsigned TIMEOUT_CYC = 50,  // Long hold
  parameter bit          HAS_MON_EN  = 1'b1 // Enable pin variant
) (
  input wire logic        sys_clk_in,                // Clock
  input wire logic        rst_b_in,                  // Reset
  input wire logic        supply_good_in,            // Supply good
  input wire logic        monitor_enable_input_in,   // Enable pin
  input wire logic        rst_pin_in,                // Pin level
  input wire logic        other_reset_in,            // Other cause
  input wire logic        src_wr_in,                 // Flag write
  input wire logic [7:0]  src_wdata_in,              // Write data
  input wire logic        rst_pin_out,               // Pin value
  input wire logic        rst_pin_oe_out,            // Pin enable
  input wire logic        sys_rst_b_out,             // Core reset
  input wire logic [7:0]  reset_source_register_out, // Flags
  input wire logic [15:0] boot_vector_out,           // Start address
  input wire logic [1:0]  reset_cause_out,           // Cause
  input wire logic        monitor_active_out         // Monitoring
);
  int unsigned good_cnt_r; // Good supply cycles in a row

  // Saturating count of good supply cycles
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      good_cnt_r <= 32'h0;
    else if (!supply_good_in)
      good_cnt_r <= 32'h0;
    else
      good_cnt_r <= good_cnt_r + {31'h0, good_cnt_r != 32'hFFFFFFFF};
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  // Supply seen low for a sustained stretch
  sequence s_supply_lost;
    !supply_good_in [*8];
  endsequence
  // Core leaves reset
  sequence s_exit;
    $rose(sys_rst_b_out);
  endsequence

  chk_boot_vec_zero: assert property (boot_vector_out == 16'h0000)
    else $error("boot vector not zero");
  chk_pin_follows_rst: assert property (
    rst_pin_oe_out == !sys_rst_b_out && !rst_pin_out)
    else $error("pin drive does not match core reset");
  chk_exit_flag: assert property (s_exit |->
    reset_source_register_out[1] == (reset_cause_out != 2'h3))
    else $error("power-on flag wrong at reset exit");
  chk_hold_count: assert property (
    s_exit ##0 (reset_cause_out != 2'h3) |-> good_cnt_r >= TIMEOUT_CYC)
    else $error("reset released before timeout");
  chk_supply_fail: assert property (
    s_supply_lost ##0 monitor_active_out |-> !sys_rst_b_out)
    else $error("no reset on supply loss");
  chk_soft_force: assert property (
    src_wr_in && src_wdata_in[1] && sys_rst_b_out |=> !sys_rst_b_out)
    else $error("flag write did not force reset");
  chk_other_short: assert property (
    other_reset_in && sys_rst_b_out |=> !sys_rst_b_out [*8])
    else $error("other reset too short");
  chk_monitor_off: assert property (
    (HAS_MON_EN && !monitor_enable_input_in) [*8] |-> !monitor_active_out)
    else $error("monitor active while disabled");
endmodule : smrc_top_chk

//--- smrc_supply_model.sv
// Behavioural supply comparator and open-drain reset pin wire
`timescale 1ns/1ps
module smrc_supply_model #(
  parameter int unsigned SETTLE_NS = 7 // Comparator response delay
) (
  input  wire logic supply_up_in,    // Supply above threshold
  input  wire logic pull_low_in,     // Outside party pulls pin low
  input  wire logic rst_pin_out_in,  // Device pin value
  input  wire logic rst_pin_oe_in,   // Device pin enable
  output logic      supply_good_out, // Comparator output
  output logic      pin_level_out    // Wire level, pulled up
);
  // Comparator lags the supply; the wire idles high
  assign #(SETTLE_NS) supply_good_out = supply_up_in;
  assign pin_level_out = !((rst_pin_oe_in && !rst_pin_out_in) || pull_low_in);
endmodule : smrc_supply_model

//--- tb_top.sv
// Self-checking bench for the supply monitor reset block
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned T = 50; // Shortened timeout
  typedef struct {
    logic [1:0] kind;  // Write, request, pin, supply
    logic       bit1;  // Write data bit one
    logic       fires; // Reset expected
    logic [1:0] cause; // Cause after exit
    logic       flag;  // Flag after exit
  } smrc_row_t;
  smrc_row_t   rows [5] = '{'{2'h3, 1'b0, 1'b1, 2'h1, 1'b1},
    '{2'h0, 1'b0, 1'b0, 2'h1, 1'b1}, '{2'h1, 1'b0, 1'b1, 2'h3, 1'b0},
    '{2'h0, 1'b1, 1'b1, 2'h2, 1'b1}, '{2'h2, 1'b0, 1'b1, 2'h3, 1'b0}};
  logic        clk = 1'b0, rst_b, sup, low, mon_en, req, wr, p_out, p_oe;
  logic        core_b, mon_act, fix_b, good, lvl;
  logic [7:0]  wdata, src;
  logic [15:0] boot;
  logic [1:0]  cause;
  int          errors = 0, checks_done = 0, len;

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Comparator and pin wire, then both device variants
  smrc_supply_model model_u (.supply_up_in(sup), .pull_low_in(low),
    .rst_pin_out_in(p_out), .rst_pin_oe_in(p_oe),
    .supply_good_out(good), .pin_level_out(lvl));
  smrc_top #(.TIMEOUT_CYC(T), .HAS_MON_EN(1'b1)) dut_u (.sys_clk_in(clk),
    .rst_b_in(rst_b), .supply_good_in(good), .rst_pin_in(lvl),
    .monitor_enable_input_in(mon_en), .other_reset_in(req),
    .src_wr_in(wr), .src_wdata_in(wdata), .rst_pin_out(p_out),
    .rst_pin_oe_out(p_oe), .sys_rst_b_out(core_b), .boot_vector_out(boot),
    .reset_source_register_out(src), .reset_cause_out(cause),
    .monitor_active_out(mon_act));
  smrc_top #(.TIMEOUT_CYC(T), .HAS_MON_EN(1'b0)) fixed_u (.sys_clk_in(clk),
    .rst_b_in(rst_b), .supply_good_in(good), .rst_pin_in(1'b1),
    .monitor_enable_input_in(mon_en), .other_reset_in(req),
    .src_wr_in(wr), .src_wdata_in(wdata), .rst_pin_out(),
    .rst_pin_oe_out(), .sys_rst_b_out(fix_b), .boot_vector_out(),
    .reset_source_register_out(), .reset_cause_out(),
    .monitor_active_out());

  // Compare one value
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Count cycles until core reset lifts, bounded
  task automatic wait_rel();
    len = 0;
    while (core_b !== 1'b1 && len < 400) begin
      @(negedge clk);
      len++;
    end
    check("released", 16'h0001, {15'h0, core_b});
  endtask : wait_rel

  function automatic logic span(input int n);
    return n >= T && n <= T + 10;
  endfunction : span

  // Drive one reset cause while running
  task automatic fire(input logic [1:0] kind, input logic bit1);
    wdata = bit1 ? 8'h02 : 8'hFD;
    wr = kind == 2'h0;
    req = kind == 2'h1;
    low = kind == 2'h2;
    sup = kind != 2'h3;
    cyc(kind[1] ? 10 : 1);
    {wr, req, low, sup} = 4'h1;
  endtask : fire

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // Watchdog
  initial begin
    #(4000 * 50);
    errors++;
    report_and_stop();
  end

  // Power-up, table of causes, then hand-written cases
  initial begin
    {rst_b, sup, low, req, wr} = 5'h00;
    mon_en = 1'b1;
    wdata = 8'h00;
    cyc(4);
    rst_b = 1'b1;
    cyc(20);
    check("held in reset", 16'h0000, {15'h0, core_b});
    sup = 1'b1;
    wait_rel();
    check("power-up span", 16'h0001, {15'h0, span(len)});
    check("flags", 16'h0002, {8'h00, src});
    $display("power-up test done");
    foreach (rows[i]) begin
      smrc_row_t r;
      r = rows[i];
      cyc(20);
      fire(r.kind, r.bit1);
      cyc(4);
      check("reset entered", {15'h0, r.fires}, {15'h0, !core_b});
      wait_rel();
      check("long hold", {15'h0, r.fires && r.cause != 2'h3},
            {15'h0, len > T / 2});
      check("cause", {14'h0, r.cause}, {14'h0, cause});
      check("power-on flag", {15'h0, r.flag}, {15'h0, src[1]});
      check("boot vector", 16'h0000, boot);
      $display("row %0d done", i);
    end
    // Supply glitch mid-timeout restarts the wait
    fire(2'h3, 1'b0);
    cyc(30);
    fire(2'h3, 1'b0);
    wait_rel();
    check("glitch span", 16'h0001, {15'h0, span(len)});
    $display("glitch test done");
    // Monitor off: only the fixed variant resets
    cyc(20);
    mon_en = 1'b0;
    cyc(10);
    sup = 1'b0;
    cyc(12);
    check("monitor active", 16'h0000, {15'h0, mon_act});
    check("core reset", 16'h0001, {15'h0, core_b});
    check("fixed variant", 16'h0000, {15'h0, fix_b});
    sup = 1'b1;
    mon_en = 1'b1;
    $display("monitor test done");
    // Second reset in mid-run
    cyc(T + 20);
    rst_b = 1'b0;
    cyc(4);
    check("pin driven", 16'h0001, {15'h0, p_oe});
    check("pin value", 16'h0000, {15'h0, p_out});
    check("flags in reset", 16'h0000, {8'h00, src});
    rst_b = 1'b1;
    wait_rel();
    check("reset span", 16'h0001, {15'h0, span(len)});
    check("flags", 16'h0002, {8'h00, src});
    check("pin released", 16'h0000, {15'h0, p_oe});
    check("cold cause", 16'h0000, {14'h0, cause});
    $display("reset test done");
    report_and_stop();
  end
endmodule : tb_top

// Checker on every instance of the top module
bind smrc_top smrc_top_chk #(.TIMEOUT_CYC(TIMEOUT_CYC),
  .HAS_MON_EN(HAS_MON_EN)) chk_u (.sys_clk_in(sys_clk_in),
  .rst_b_in(rst_b_in), .supply_good_in(supply_good_in),
  .monitor_enable_input_in(monitor_enable_input_in),
  .rst_pin_in(rst_pin_in), .other_reset_in(other_reset_in),
  .src_wr_in(src_wr_in), .src_wdata_in(src_wdata_in),
  .rst_pin_out(rst_pin_out), .rst_pin_oe_out(rst_pin_oe_out),
  .sys_rst_b_out(sys_rst_b_out), .boot_vector_out(boot_vector_out),
  .reset_source_register_out(reset_source_register_out),
  .reset_cause_out(reset_cause_out),
  .monitor_active_out(monitor_active_out));
